// file: tb/command_source_selector_properties.sv
// Port checks of the command source selector
`timescale 1ns/1ps
module source_selector_checker (
   input wire clock, // Clock
   input wire arst_n, // Reset
   input wire wb_cyc_i, // Cycle
   input wire wb_stb_i, // Strobe
   input wire wb_ack_o, // Ack
   input wire [15:0] port1_freq, // P1 freq
   input wire [15:0] port2_freq, // P2 freq
   input wire [15:0] fieldbus_freq, // Bus freq
   input wire [8:0] port1_run, // P1 run
   input wire [8:0] port2_run, // P2 run
   input wire [8:0] fieldbus_run, // Bus run
   input wire [15:0] freq_cmd, // Freq out
   input wire forward_run_cmd, // Fwd out
   input wire reverse_run_cmd, // Rev out
   input wire [6:0] general_input_cmd, // X out
   input wire [1:0] freq_src_out, // Freq src
   input wire [1:0] run_src_out // Run src
);
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   // Whole run word, so a split source shows up
   wire [8:0] rw = {general_input_cmd, reverse_run_cmd, forward_run_cmd};
   a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack late");
   a_ack_has_request: assert property (wb_ack_o |-> $past(wb_stb_i) && $past(wb_cyc_i))
      else $error("ack without request");
   a_freq_port_one: assert property (freq_src_out == 2'h1 |-> freq_cmd == $past(port1_freq))
      else $error("freq not port 1");
   a_freq_port_two: assert property (freq_src_out == 2'h2 |-> freq_cmd == $past(port2_freq))
      else $error("freq not port 2");
   a_freq_bus_word: assert property (freq_src_out == 2'h3 |-> freq_cmd == $past(fieldbus_freq))
      else $error("freq not fieldbus");
   a_run_port_one: assert property (run_src_out == 2'h1 |-> rw == $past(port1_run))
      else $error("run not port 1");
   a_run_port_two: assert property (run_src_out == 2'h2 |-> rw == $past(port2_run))
      else $error("run not port 2");
   a_run_bus_word: assert property (run_src_out == 2'h3 |-> rw == $past(fieldbus_run))
      else $error("run not fieldbus");
endmodule
bind command_source_selector source_selector_checker u_source_selector_checker (.clock,
   .arst_n, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .port1_freq, .port2_freq, .fieldbus_freq,
   .port1_run, .port2_run, .fieldbus_run, .freq_cmd, .forward_run_cmd, .reverse_run_cmd,
   .general_input_cmd, .freq_src_out, .run_src_out);

// file: tb/command_source_selector_test.sv
// Self-checking bench of the command source selector
`timescale 1ns/1ps
`include "source_select_regs.vh"
module command_source_selector_test;
   reg clock = 1'b0, arst_n = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   reg link_enable_input = 1'b0, refresh = 1'b0;
   reg [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0, m_ser;
   reg [31:0] wb_dat_i = 32'h0, rd, rn, seed = 32'h595789C6;
   reg [15:0] local_freq_primary = 16'h0, local_freq_alt = 16'h0, multistep_freq = 16'h0;
   reg [8:0] keypad_run = 9'h0, terminal_run = 9'h0;
   reg [1:0] m_fb;
   reg [7:0] m_cfg;
   reg m_rej;
   wire [31:0] wb_dat_o;
   wire wb_ack_o, forward_run_cmd, reverse_run_cmd;
   wire [15:0] port1_freq, port2_freq, fieldbus_freq, freq_cmd;
   wire [8:0] port1_run, port2_run, fieldbus_run;
   wire [6:0] general_input_cmd;
   wire [1:0] freq_src_out, run_src_out;
   integer bad_count = 0, total_checks = 0, i;
   always #20 clock = ~clock;
   command_source_selector u_command_source_selector (.clock, .arst_n, .wb_cyc_i, .wb_stb_i,
      .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .link_enable_input,
      .local_freq_primary, .local_freq_alt, .multistep_freq, .port1_freq, .port2_freq,
      .fieldbus_freq, .keypad_run, .terminal_run, .port1_run, .port2_run, .fieldbus_run,
      .freq_cmd, .forward_run_cmd, .reverse_run_cmd, .general_input_cmd, .freq_src_out,
      .run_src_out);
   remote_link_model u_remote_link_model (.clock, .arst_n, .refresh, .port1_freq,
      .port2_freq, .fieldbus_freq, .port1_run, .port2_run, .fieldbus_run);
   // ****************************************
   // Checks and bus cycles
   // ****************************************
   task summarize;
      begin
         $display("checks %0d mismatches %0d", total_checks, bad_count);
         if (bad_count == 0 && total_checks > 0) $display("Regression OK");
         else $display("Regression broken");
         $finish;
      end
   endtask
   task chk_bus(input [31:0] got, input [31:0] exp);
      begin
         total_checks = total_checks + 1;
         if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("FAIL t=%0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   // Command word checks reuse the reporting path
   task chk_cmd(input [28:0] got, input [28:0] exp);
      chk_bus({3'h0, got}, {3'h0, exp});
   endtask
   // Classic cycle: hold until ack is seen, release at that edge
   task bus(input w, input [3:0] a, input [31:0] d, input [3:0] s);
      integer n;
      begin
         @(posedge clock);
         {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'h3, w, a, d, s};
         n = 0;
         @(posedge clock);
         while (wb_ack_o !== 1'b1 && n < 20) begin
            @(posedge clock);
            n = n + 1;
         end
         if (n == 20) begin
            bad_count = bad_count + 1;
            summarize;
         end
         // Ack sampled high at this edge: take the data and release here
         rd = wb_dat_o;
         {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
      end
   endtask
   task rdchk(input [3:0] a, input [31:0] e);
      begin
         bus(1'b0, a, 32'h0, 4'hF);
         chk_bus(rd, e);
      end
   endtask
   // Reference routing: serial table, fieldbus override, link gate
   function [3:0] srcs(input x);
      reg [1:0] f, r;
      begin
         f = (m_ser == 1 || m_ser == 3 || m_ser == 7) ? 2'h1 : (m_ser == 4 || m_ser == 5 || m_ser == 8) ? 2'h2 : 2'h0;
         r = (m_ser == 2 || m_ser == 3 || m_ser == 5) ? 2'h1 : (m_ser >= 6) ? 2'h2 : 2'h0;
         if (m_fb[0]) f = 2'h3;
         if (m_fb[1]) r = 2'h3;
         if (m_cfg[3] && !link_enable_input) {f, r} = 4'h0;
         srcs = {r, f};
      end
   endfunction
   task check_all;
      reg [3:0] s;
      reg [15:0] ef;
      reg [8:0] er;
      begin
         s = srcs(1'b0);
         case (s[1:0])
            2'h0: ef = (m_cfg[1:0] == 2'h1) ? local_freq_alt : (m_cfg[1:0] == 2'h2) ? multistep_freq : local_freq_primary;
            2'h1: ef = port1_freq;
            2'h2: ef = port2_freq;
            default: ef = fieldbus_freq;
         endcase
         case (s[3:2])
            2'h0: er = m_cfg[2] ? keypad_run : terminal_run;
            2'h1: er = port1_run;
            2'h2: er = port2_run;
            default: er = fieldbus_run;
         endcase
         chk_cmd({freq_cmd, general_input_cmd, reverse_run_cmd, forward_run_cmd, freq_src_out, run_src_out}, {ef, er, s[1:0], s[3:2]});
         rdchk(`OFS_STATUS, {26'h0, m_rej, !m_cfg[3] || link_enable_input, s});
      end
   endtask
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      {m_ser, m_fb, m_cfg, m_rej} = 15'h0;
      repeat (12) @(posedge clock);
      arst_n <= 1'b1;
      rdchk(`OFS_SERIAL_SEL, 32'h0);
      rdchk(`OFS_LOCAL_CFG, 32'h0);
      check_all;
      // Every code pair with random local setup and link level
      for (i = 0; i < 36; i = i + 1) begin
         m_ser = 4'(i % 9);
         m_fb = 2'(i / 9);
         rn = $random(seed);
         m_cfg = {4'h0, rn[3:0]};
         bus(1'b1, `OFS_SERIAL_SEL, {28'h0, m_ser}, 4'hF);
         bus(1'b1, `OFS_FIELDBUS_SEL, {30'h0, m_fb}, 4'hF);
         bus(1'b1, `OFS_LOCAL_CFG, {24'h0, m_cfg}, 4'hF);
         {local_freq_primary, local_freq_alt} <= $random(seed);
         rn = $random(seed);
         {multistep_freq, keypad_run, terminal_run[6:0]} <= rn;
         {link_enable_input, terminal_run[8:7]} <= rn[6:4];
         refresh <= 1'b1;
         @(posedge clock);
         refresh <= 1'b0;
         repeat (3) @(posedge clock);
         @(negedge clock);
         check_all;
      end
      // Out-of-range codes and a write without the low byte are dropped
      for (i = 9; i < 17; i = i + 1) bus(1'b1, `OFS_SERIAL_SEL, 32'(i), 4'hF);
      bus(1'b1, `OFS_FIELDBUS_SEL, 32'h4, 4'hF);
      bus(1'b1, `OFS_SERIAL_SEL, 32'h3, 4'hE);
      m_rej = 1'b1;
      rdchk(`OFS_SERIAL_SEL, {28'h0, m_ser});
      rdchk(`OFS_FIELDBUS_SEL, {30'h0, m_fb});
      rdchk(4'h2, 32'h0);
      repeat (2) @(negedge clock);
      check_all;
      // Second reset in mid-run returns to all-local
      @(posedge clock);
      arst_n <= 1'b0;
      repeat (2) @(posedge clock);
      arst_n <= 1'b1;
      {m_ser, m_fb, m_cfg, m_rej} = 15'h0;
      repeat (3) @(negedge clock);
      check_all;
      summarize;
   end
endmodule

// file: tb/remote_link_model.sv
// Remote controller model: serial and fieldbus command words
`timescale 1ns/1ps
module remote_link_model (
   input wire clock, // Clock
   input wire arst_n, // Reset
   input wire refresh, // New telegram
   output wire [15:0] port1_freq, // P1 freq
   output wire [15:0] port2_freq, // P2 freq
   output wire [15:0] fieldbus_freq, // Bus freq
   output wire [8:0] port1_run, // P1 run
   output wire [8:0] port2_run, // P2 run
   output wire [8:0] fieldbus_run // Bus run
);
   reg [31:0] pat_reg;
   // Words change only on a telegram, overlapping slices keep sources distinct
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) pat_reg <= 32'h13579BDF;
      else if (refresh) pat_reg <= pat_reg * 32'h0019660D + 32'h3C6EF35F;
   end
   assign port1_freq = pat_reg[15:0];
   assign port2_freq = pat_reg[31:16];
   assign fieldbus_freq = pat_reg[23:8];
   assign port1_run = pat_reg[8:0];
   assign port2_run = pat_reg[20:12];
   assign fieldbus_run = pat_reg[31:23];
endmodule

// file: verilog/command_source_selector.v
// Command source selector: picks frequency and run command sources for the drive core
// Functional notes
// - Serial code 0..8 picks freq/run serial sources
// - Fieldbus code 0..3 overrides freq/run sources
// - Serial code for ports, fieldbus code for fieldbus
// - Active link enable applies both codes
// - Inactive link enable forces all-local sources
// - No link-enable assignment means always enabled
// - Run word is forward, reverse, X1..X7 inputs
// - Only one run source active at once
// - Local frequency from primary, alternate or multistep
// - Local run from keypad or terminals
//
// Design decisions made here: the address map and register access over Wishbone.
`timescale 1ns/1ps
`include "source_select_regs.vh"

module command_source_selector (
   input wire clock,                       // System clock, 25 MHz
   input wire arst_n,                      // Asynchronous reset, active low
   // Wishbone slave
   input wire wb_cyc_i,                    // Bus cycle
   input wire wb_stb_i,                    // Strobe
   input wire wb_we_i,                     // Write enable
   input wire [3:0] wb_adr_i,              // Byte address
   input wire [3:0] wb_sel_i,              // Byte selects
   input wire [31:0] wb_dat_i,             // Write data
   output reg [31:0] wb_dat_o,             // Read data
   output reg wb_ack_o,                    // Acknowledge
   // Link enable terminal
   input wire link_enable_input,           // Link enable level, high = on
   // Frequency sources
   input wire [15:0] local_freq_primary,   // Primary local frequency
   input wire [15:0] local_freq_alt,       // Alternate local frequency
   input wire [15:0] multistep_freq,       // Multistep frequency
   input wire [15:0] port1_freq,           // Port 1 frequency
   input wire [15:0] port2_freq,           // Port 2 frequency
   input wire [15:0] fieldbus_freq,        // Fieldbus frequency
   // Run sources: bit0 fwd, bit1 rev, bits 8:2 general inputs
   input wire [8:0] keypad_run,            // Keypad run word
   input wire [8:0] terminal_run,          // Terminal run word
   input wire [8:0] port1_run,             // Port 1 run word
   input wire [8:0] port2_run,             // Port 2 run word
   input wire [8:0] fieldbus_run,          // Fieldbus run word
   // To drive core
   output reg [15:0] freq_cmd,             // Selected frequency
   output reg forward_run_cmd,             // Forward run
   output reg reverse_run_cmd,             // Reverse run
   output reg [6:0] general_input_cmd,     // General inputs X1..X7
   output reg [1:0] freq_src_out,          // Active frequency source
   output reg [1:0] run_src_out            // Active run source
);

   // ****************************************
   // Register map
   // ****************************************
   // 0x0 serial-link code: four bits, codes 0 to 8
   // 0x4 fieldbus code: two bits, codes 0 to 3
   // 0x8 local setup, any byte accepted:
   //     [1:0] local frequency: primary, alternate, multistep, primary
   //     [2] run from keypad when set, from terminals when clear
   //     [3] link-enable terminal assigned; clear means always on
   // 0xC status, read only:
   //     [1:0] frequency source, [3:2] run source
   //     [4] link active, [5] last code write refused
   // Unmapped offsets read zero and drop writes, yet still ack
   // Only byte lane 0 carries data; a write without it is dropped
   // Code registers reset to zero: all local, fieldbus unused
   // Setup resets to zero: primary frequency, terminals, always on
   // Status shows the routing in force, not the one just written

   // ****************************************
   // Timing
   // ****************************************
   // Requests are taken at the edge that sees strobe with ack low
   // Ack and read data follow one edge later; ack lasts one cycle
   // A code write, or a setup write to bits 2:0, reaches the outputs two edges later; bit 3 passes the link flop and takes three
   // The terminal passes one flop first, so it also takes two edges
   // A new word from the chosen source shows one edge later
   // The terminal is sampled once per clock; shorter pulses are lost
   // Fieldbus bits override the serial table per command type
   // With the link off, both commands come from the local sources,
   // even while the fieldbus code asks for the fieldbus
   // A refused code keeps the old routing and sets the status flag
   // No long counts or timers; every path is one to three flops

   // ****************************************
   // Register file
   // ****************************************
   reg [3:0] serial_source_select_reg;
   reg [1:0] fieldbus_source_select_reg;
   reg [7:0] local_cfg_reg;
   reg reject_flag_reg;
   reg link_active_reg;

   // Decoded request and write fields
   wire bus_req;
   wire bus_wr;
   wire [7:0] wr_byte;
   wire [3:0] serial_wr_val;
   wire [3:0] serial_wr_upper;
   wire [1:0] fieldbus_wr_val;
   wire [5:0] fieldbus_wr_upper;
   wire serial_bad;
   wire fieldbus_bad;
   wire serial_wr;
   wire fieldbus_wr;
   wire cfg_wr;

   // A request counts once; the ack that answers it masks the held strobe
   assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign bus_wr = bus_req & wb_we_i & wb_sel_i[`WR_LANE];

   // Fields of the written byte
   assign wr_byte = wb_dat_i[`WR_BYTE_MSB:0];
   assign serial_wr_val = wr_byte[`WR_SERIAL_MSB:0];
   assign serial_wr_upper = wr_byte[`WR_BYTE_MSB:`WR_SERIAL_UP_LSB];
   assign fieldbus_wr_val = wr_byte[`WR_FB_MSB:0];
   assign fieldbus_wr_upper = wr_byte[`WR_BYTE_MSB:`WR_FB_UP_LSB];

   // Any upper data bit set makes the code out of range
   assign serial_bad = (serial_wr_upper != 4'h0) || (serial_wr_val > `SERIAL_CODE_MAX);
   assign fieldbus_bad = (fieldbus_wr_upper != 6'h00);

   // Write strobes of the three writable registers
   assign serial_wr = bus_wr && (wb_adr_i == `OFS_SERIAL_SEL);
   assign fieldbus_wr = bus_wr && (wb_adr_i == `OFS_FIELDBUS_SEL);
   assign cfg_wr = bus_wr && (wb_adr_i == `OFS_LOCAL_CFG);

   // Ack one cycle after the strobe, dropped the cycle after
   // The held strobe is masked while ack is high, so one request is one ack
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= bus_req;
      end
   end

   // Serial code; a refused value leaves the routing as it was
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         serial_source_select_reg <= `SERIAL_CODE_RST;
      end else if (serial_wr && !serial_bad) begin
         serial_source_select_reg <= serial_wr_val;
      end
   end

   // Fieldbus code, refused in the same way as the serial code
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         fieldbus_source_select_reg <= `FIELDBUS_CODE_RST;
      end else if (fieldbus_wr && !fieldbus_bad) begin
         fieldbus_source_select_reg <= fieldbus_wr_val;
      end
   end

   // Local setup takes any byte; bits 7:4 are stored but drive nothing
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         local_cfg_reg <= `LOCAL_CFG_RST;
      end else if (cfg_wr) begin
         local_cfg_reg <= wr_byte;
      end
   end

   // Refusal flag: set by a bad code write, cleared by a good one
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         reject_flag_reg <= 1'b0;
      end else if (serial_wr) begin
         reject_flag_reg <= serial_bad;
      end else if (fieldbus_wr) begin
         reject_flag_reg <= fieldbus_bad;
      end
   end

   wire [1:0] local_freq_choice;
   wire keypad_selected;
   wire terminal_assigned;

   // Fields of the local setup
   assign local_freq_choice = local_cfg_reg[`CFG_FREQ_MSB:`CFG_FREQ_LSB];
   assign keypad_selected = local_cfg_reg[`CFG_RUN_BIT];
   assign terminal_assigned = local_cfg_reg[`CFG_LE_ASSIGNED];

   // ****************************************
   // Read path
   // ****************************************
   reg [31:0] rd_next;
   wire [31:0] status_word;

   // Status fields: refusal, link, run source, frequency source
   assign status_word = {26'h0000000, reject_flag_reg, link_active_reg,
                         run_src_out, freq_src_out};

   // Unmapped addresses read zero and still get an ack
   always @* begin
      case (wb_adr_i)
         `OFS_SERIAL_SEL: rd_next = {28'h0000000, serial_source_select_reg};
         `OFS_FIELDBUS_SEL: rd_next = {30'h00000000, fieldbus_source_select_reg};
         `OFS_LOCAL_CFG: rd_next = {24'h000000, local_cfg_reg};
         `OFS_STATUS: rd_next = status_word;
         default: rd_next = 32'h00000000;
      endcase
   end

   // Read data is loaded only on a read, so it stands until the next one
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         wb_dat_o <= 32'h00000000;
      end else if (bus_req && !wb_we_i) begin
         wb_dat_o <= rd_next;
      end
   end

   // ****************************************
   // Link enable
   // ****************************************
   wire link_active_next;

   // Unassigned terminal counts as permanently on
   assign link_active_next = ~terminal_assigned | link_enable_input;

   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         link_active_reg <= 1'b0;
      end else begin
         link_active_reg <= link_active_next;
      end
   end

   // ****************************************
   // Source decode
   // ****************************************
   wire [1:0] serial_freq_src;
   wire [1:0] serial_run_src;
   reg [1:0] freq_src_next;
   reg [1:0] run_src_next;
   wire fieldbus_takes_freq;
   wire fieldbus_takes_run;

   // One bit of the fieldbus code for each command type
   assign fieldbus_takes_freq = fieldbus_source_select_reg[`FB_FREQ_BIT];
   assign fieldbus_takes_run = fieldbus_source_select_reg[`FB_RUN_BIT];

   serial_code_decode u_serial_decode (
      .code(serial_source_select_reg),
      .freq_src(serial_freq_src),
      .run_src(serial_run_src)
   );

   // Fieldbus code only overrides; serial code only names the ports
   // Link gate last, so an inactive terminal beats both codes
   always @* begin
      freq_src_next = serial_freq_src;
      run_src_next = serial_run_src;
      if (fieldbus_takes_freq) begin
         freq_src_next = `SRC_FIELDBUS;
      end
      if (fieldbus_takes_run) begin
         run_src_next = `SRC_FIELDBUS;
      end
      if (!link_active_reg) begin
         freq_src_next = `SRC_LOCAL;
         run_src_next = `SRC_LOCAL;
      end
   end

   // ****************************************
   // Local sources
   // ****************************************
   reg [15:0] local_freq;
   wire [8:0] local_run;

   // Multistep selection takes the place of the configured channel
   // Choice 3 is unused and falls back to the primary channel
   always @* begin
      case (local_freq_choice)
         `LFREQ_PRIMARY: local_freq = local_freq_primary;
         `LFREQ_ALT: local_freq = local_freq_alt;
         `LFREQ_MULTI: local_freq = multistep_freq;
         default: local_freq = local_freq_primary;
      endcase
   end

   assign local_run = keypad_selected ? keypad_run : terminal_run;

   // ****************************************
   // Output selection
   // ****************************************
   wire [15:0] freq_sel;
   wire [8:0] run_sel;
   wire run_fwd_sel;
   wire run_rev_sel;
   wire [6:0] run_gen_sel;

   source_mux #(.W(`FREQ_W)) u_freq_mux (
      .sel(freq_src_next),
      .in0(local_freq),
      .in1(port1_freq),
      .in2(port2_freq),
      .in3(fieldbus_freq),
      .out(freq_sel)
   );

   // Whole run word from one source, so local fwd/rev never mixes with link inputs
   source_mux #(.W(`RUN_W)) u_run_mux (
      .sel(run_src_next),
      .in0(local_run),
      .in1(port1_run),
      .in2(port2_run),
      .in3(fieldbus_run),
      .out(run_sel)
   );

   // Split the chosen run word into its terminals, all from one source
   assign run_fwd_sel = run_sel[`RUN_FWD_BIT];
   assign run_rev_sel = run_sel[`RUN_REV_BIT];
   assign run_gen_sel = run_sel[`RUN_GEN_MSB:`RUN_GEN_LSB];

   // Registered so a source change lands cleanly on one edge
   // Reset value is all local with every run input off
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         freq_cmd <= `FREQ_CMD_RST;
         forward_run_cmd <= 1'b0;
         reverse_run_cmd <= 1'b0;
         general_input_cmd <= `GEN_CMD_RST;
         freq_src_out <= `SRC_LOCAL;
         run_src_out <= `SRC_LOCAL;
      end else begin
         freq_cmd <= freq_sel;
         forward_run_cmd <= run_fwd_sel;
         reverse_run_cmd <= run_rev_sel;
         general_input_cmd <= run_gen_sel;
         freq_src_out <= freq_src_next;
         run_src_out <= run_src_next;
      end
   end

endmodule

// file: verilog/serial_code_decode.v
// Decoder of the serial-link source code into frequency and run sources
`timescale 1ns/1ps
`include "source_select_regs.vh"

module serial_code_decode (
   input wire [3:0] code,      // Serial-link source code
   output reg [1:0] freq_src,  // Frequency source
   output reg [1:0] run_src    // Run source
);

   // ****************************************
   // Table decode
   // ****************************************
   // Out-of-range codes never reach here; default keeps everything local
   always @* begin
      case (code)
         4'h0: begin freq_src = `SRC_LOCAL; run_src = `SRC_LOCAL; end
         4'h1: begin freq_src = `SRC_PORT1; run_src = `SRC_LOCAL; end
         4'h2: begin freq_src = `SRC_LOCAL; run_src = `SRC_PORT1; end
         4'h3: begin freq_src = `SRC_PORT1; run_src = `SRC_PORT1; end
         4'h4: begin freq_src = `SRC_PORT2; run_src = `SRC_LOCAL; end
         4'h5: begin freq_src = `SRC_PORT2; run_src = `SRC_PORT1; end
         4'h6: begin freq_src = `SRC_LOCAL; run_src = `SRC_PORT2; end
         4'h7: begin freq_src = `SRC_PORT1; run_src = `SRC_PORT2; end
         4'h8: begin freq_src = `SRC_PORT2; run_src = `SRC_PORT2; end
         default: begin
            freq_src = `SRC_LOCAL;
            run_src = `SRC_LOCAL;
         end
      endcase
   end

endmodule

// file: verilog/source_mux.v
// Four-way multiplexer choosing one command word by source code
`timescale 1ns/1ps

module source_mux #(
   parameter W = 16
) (
   input wire [1:0] sel,       // Source code
   input wire [W-1:0] in0,     // Local
   input wire [W-1:0] in1,     // Port 1
   input wire [W-1:0] in2,     // Port 2
   input wire [W-1:0] in3,     // Fieldbus
   output reg [W-1:0] out      // Chosen word
);

   // Plain selection; the caller registers the result
   always @* begin
      case (sel)
         2'h0: out = in0;
         2'h1: out = in1;
         2'h2: out = in2;
         default: out = in3;
      endcase
   end

endmodule

// file: verilog/source_select_regs.vh
// Constants of the command source selector: register map, field codes and reset values
`ifndef SOURCE_SELECT_REGS_VH
`define SOURCE_SELECT_REGS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_SERIAL_SEL   4'h0
`define OFS_FIELDBUS_SEL 4'h4
`define OFS_LOCAL_CFG    4'h8
`define OFS_STATUS       4'hC

// ****************************************
// Code limits and reset values
// ****************************************
`define SERIAL_CODE_MAX   4'h8
`define FIELDBUS_CODE_MAX 2'h3
`define SERIAL_CODE_RST   4'h0
`define FIELDBUS_CODE_RST 2'h0
`define LOCAL_CFG_RST     8'h00

// Local configuration register fields
`define CFG_FREQ_LSB    0
`define CFG_FREQ_MSB    1
`define CFG_RUN_BIT     2
`define CFG_LE_ASSIGNED 3

// Source selection codes
`define SRC_LOCAL    2'h0
`define SRC_PORT1    2'h1
`define SRC_PORT2    2'h2
`define SRC_FIELDBUS 2'h3

// Local frequency choice codes
`define LFREQ_PRIMARY 2'h0
`define LFREQ_ALT     2'h1
`define LFREQ_MULTI   2'h2

// Widths
`define FREQ_W 16
`define RUN_W  9

// Written byte fields: only byte lane 0 carries a code
`define WR_LANE          0
`define WR_BYTE_MSB      7
`define WR_SERIAL_MSB    3
`define WR_SERIAL_UP_LSB 4
`define WR_FB_MSB        1
`define WR_FB_UP_LSB     2

// Fieldbus code bits, one per command type
`define FB_FREQ_BIT 0
`define FB_RUN_BIT  1

// Run word fields
`define RUN_FWD_BIT 0
`define RUN_REV_BIT 1
`define RUN_GEN_LSB 2
`define RUN_GEN_MSB 8

// Reset values of the command outputs
`define FREQ_CMD_RST 16'h0000
`define GEN_CMD_RST  7'h00

`endif
